/* File: rtl/cpu_dma_priority_gate.sv */
// Purpose: gate dma activation by cpu level, clear dma-owned sources,
//          and time the windows where interrupt acceptance is held off
// Assumes: all inputs synchronous to clk_sys; one state per cycle
// Notes:   Avalon-MM slave answers one cycle after the request
`timescale 1ns/1ps

module cpu_dma_priority_gate
  import prio_gate_pkg::*;
#(
  parameter int NCH  = 4,
  parameter int NIRQ = 8
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // avalon-mm register slave
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // cpu mask state
  input  wire logic                  ccr_mask_bit,
  input  wire logic [2:0]            interrupt_mask_level,
  input  wire logic                  int_ctrl_mode2,
  // cpu instruction events
  input  wire logic                  ctrl_insn_done,
  input  wire logic                  insn_end,
  input  wire logic                  block_move_byte,
  input  wire logic                  block_move_word,
  input  wire logic                  string_block_transfer,
  input  wire logic                  transfer_cycle_end,
  // interrupt requests, higher index wins
  input  wire logic                  nmi_req,
  input  wire logic [NIRQ-1:0]       irq_req,
  output logic                       irq_accept,
  output logic                       irq_accept_nmi,
  output logic      [3:0]            irq_accept_id,
  output logic                       save_pc_at_insn,
  // per channel selected source
  input  wire logic [NCH-1:0]        src_req,
  input  wire logic [NCH-1:0]        dma_access_done,
  output logic      [NCH-1:0]        dma_act_req,
  output logic      [NCH-1:0]        cpu_src_req,
  output logic      [NCH-1:0]        src_clear
);

  // ===========================================================
  // elaboration checks
  initial begin
    if (NCH < 1 || NCH > 8) begin
      $error("NCH must be 1 to 8");
    end
    if (NIRQ < 1 || NIRQ > 16) begin
      $error("NIRQ must be 1 to 16");
    end
  end

  // ===========================================================
  // state
  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic                      gate_en;
    logic                      auto_pri;
    logic [PRI_W-1:0]          sw_pri;
    logic [NCH-1:0][PRI_W-1:0] ch_pri;
    logic [NCH-1:0]            ch_own;
    logic [NCH-1:0]            ch_en;
    logic [MASK_DELAY_CYC-1:0] mask_pipe;
    logic [1:0]                blk_cnt;
    logic [NIRQ-1:0]           latched;
    logic                      nmi_latched;
    logic                      acc;
    logic                      acc_nmi;
    logic [3:0]                acc_id;
    logic                      acc_pc_insn;
    logic [NCH-1:0]            clr;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [PRI_W-1:0] cpu_lvl;
  logic [NCH-1:0]   held;
  logic [NCH-1:0]   to_dma;
  logic             blocked;
  logic             window;
  logic [NIRQ-1:0]  pend;
  logic [3:0]       top_id;
  logic             top_any;
  logic             wr_go;
  logic             rd_go;
  logic [31:0]      rd_val;
  logic [31:0]      wmask;
  logic [31:0]      wval;

  // ===========================================================
  // effective cpu level
  always_comb begin
    if (s_q.auto_pri) begin
      if (int_ctrl_mode2) begin
        cpu_lvl = interrupt_mask_level;
      end else begin
        // delayed so the new mask is seen two states late
        cpu_lvl = {s_q.mask_pipe[MASK_DELAY_CYC-1],
                   MODE0_LOW};
      end
    end else begin
      cpu_lvl = s_q.sw_pri;
    end
  end

  // ===========================================================
  // per channel gate and routing
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign to_dma[g] = s_q.ch_en[g] & s_q.ch_own[g];
      // only a strictly higher cpu level holds the channel
      assign held[g] = s_q.gate_en &
                       (cpu_lvl > s_q.ch_pri[g]);
      assign dma_act_req[g] = src_req[g] & s_q.ch_en[g] &
                              ~held[g];
      assign cpu_src_req[g] = src_req[g] & ~to_dma[g];
    end
  endgenerate

  // ===========================================================
  // interrupt acceptance window
  assign pend = s_q.latched | irq_req;

  always_comb begin
    top_id  = 4'h0;
    top_any = 1'b0;
    for (int i = 0; i < NIRQ; i++) begin
      if (pend[i]) begin
        top_id  = 4'(i);
        top_any = 1'b1;
      end
    end
  end

  // refuse after control insns and while our registers are written
  assign blocked = ctrl_insn_done | (s_q.blk_cnt != 2'h0) |
                   avs_write;

  always_comb begin
    if (block_move_byte) begin
      window = 1'b0;
    end else if (block_move_word | string_block_transfer) begin
      window = transfer_cycle_end;
    end else begin
      window = insn_end;
    end
  end

  // ===========================================================
  // avalon decode
  assign wr_go = avs_write & s_q.ack;
  assign rd_go = avs_read & ~s_q.ack;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (avs_address == PRIO_CTRL_OFS) begin
      rd_val[GATE_EN_BIT]                 = s_q.gate_en;
      rd_val[AUTO_PRI_BIT]                = s_q.auto_pri;
      rd_val[CPU_PRI_LSB +: PRI_W]        = cpu_lvl;
    end else if (avs_address == STATUS_OFS) begin
      rd_val[ST_HELD_LSB +: NCH]          = held;
      rd_val[ST_BLOCK_BIT]                = blocked;
      rd_val[ST_LVL_LSB +: PRI_W]         = cpu_lvl;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (avs_address == 8'(CH_BASE_OFS + CH_STRIDE * c)) begin
          rd_val[CH_PRI_LSB +: PRI_W]     = s_q.ch_pri[c];
          rd_val[CH_OWN_BIT]              = s_q.ch_own[c];
          rd_val[CH_EN_BIT]               = s_q.ch_en[c];
        end
      end
    end
  end

  // ===========================================================
  // next state
  always_comb begin
    s_d = s_q;
    wval = 32'h0;

    // one wait state per access
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    if (rd_go) begin
      s_d.rdata = rd_val;
    end

    s_d.mask_pipe = {s_q.mask_pipe[MASK_DELAY_CYC-2:0],
                     ccr_mask_bit};

    if (ctrl_insn_done) begin
      s_d.blk_cnt = BLOCK_CYC;
    end else if (s_q.blk_cnt != 2'h0) begin
      s_d.blk_cnt = s_q.blk_cnt - 2'h1;
    end

    if (wr_go) begin
      if (avs_address == PRIO_CTRL_OFS) begin
        wval = (avs_writedata & wmask) |
               ({24'h0, s_q.gate_en, s_q.auto_pri, 3'h0, s_q.sw_pri}
                & ~wmask);
        s_d.gate_en  = wval[GATE_EN_BIT];
        s_d.auto_pri = wval[AUTO_PRI_BIT];
        if (!s_q.auto_pri) begin
          s_d.sw_pri = wval[CPU_PRI_LSB +: PRI_W];
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (avs_address == 8'(CH_BASE_OFS + CH_STRIDE * c) &&
            avs_byteenable[0]) begin
          s_d.ch_pri[c] = avs_writedata[CH_PRI_LSB +: PRI_W];
          s_d.ch_own[c] = avs_writedata[CH_OWN_BIT];
          s_d.ch_en[c]  = avs_writedata[CH_EN_BIT];
        end
      end
    end

    // only dma-owned sources are cleared by the dma access
    for (int c = 0; c < NCH; c++) begin
      s_d.clr[c] = dma_access_done[c] & s_q.ch_en[c] &
                   s_q.ch_own[c];
    end

    // catch requests so disabling mid-insn cannot lose them
    s_d.latched     = pend;
    s_d.nmi_latched = s_q.nmi_latched | nmi_req;
    s_d.acc         = 1'b0;
    s_d.acc_nmi     = 1'b0;
    if (window && !blocked &&
        (top_any || s_q.nmi_latched || nmi_req)) begin
      s_d.acc         = 1'b1;
      s_d.acc_nmi     = s_q.nmi_latched | nmi_req;
      s_d.acc_id      = top_id;
      s_d.acc_pc_insn = string_block_transfer;
      if (s_q.nmi_latched | nmi_req) begin
        s_d.nmi_latched = 1'b0;
      end else begin
        // the rest are dropped; live levels reassert themselves
        s_d.latched = '0;
      end
    end
  end

  // ===========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q             <= '0;
      s_q.gate_en     <= GATE_EN_RST;
      s_q.auto_pri    <= AUTO_RST;
      s_q.sw_pri      <= PRI_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================
  // outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign irq_accept      = s_q.acc;
  assign irq_accept_nmi  = s_q.acc_nmi;
  assign irq_accept_id   = s_q.acc_id;
  assign save_pc_at_insn = s_q.acc_pc_insn;
  assign src_clear       = s_q.clr;

endmodule

/* File: rtl/prio_gate_pkg.sv */
// Purpose: constants for the cpu/dma priority gate and acceptance window
// Assumes: one state equals one clk_sys cycle
// Notes:   byte addresses on a 32-bit Avalon-MM slave
//
// Overview of operation
// - owned enabled source goes to dma only
// - dma-owned source cleared after dma access
// - peripheral sources cleared on dma register access; src_clear here fires only for enabled dma-owned sources
// - gate enable filters dma requests, else pass
// - cpu level and four channel levels, 3 bits
// - hold request while cpu level exceeds channel
// - each channel gated independently of others
// - auto mode tracks mask, software writes ignored
// - manual mode uses software written level only
// - mode 0: mask bit to top bit
// - mode 2: mask level copied bit for bit
// - request during disabling instruction still serviced
// - higher pending request wins, disabled one dropped
// - refuse all requests after control instructions
// - new mask effective two states after instruction; here the mode 2 level is used without delay
// - block acceptance three states and during writes
// - byte block move defers all requests to end
// - word move accepts at cycle end, pc next
// - string move accepts at cycle end, pc insn
package prio_gate_pkg;

  // ===========================================================
  // register map
  localparam logic [7:0] PRIO_CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] CH_BASE_OFS     = 8'h10;
  localparam logic [7:0] CH_STRIDE       = 8'h04;

  // ===========================================================
  // cpu_priority_ctrl_reg fields
  localparam int GATE_EN_BIT  = 7;
  localparam int AUTO_PRI_BIT = 6;
  localparam int CPU_PRI_LSB  = 0;

  // ===========================================================
  // dma_mode_ctrl_reg fields
  localparam int CH_PRI_LSB   = 0;
  localparam int CH_OWN_BIT   = 3;
  localparam int CH_EN_BIT    = 4;

  // ===========================================================
  // status register fields
  localparam int ST_HELD_LSB  = 0;
  localparam int ST_BLOCK_BIT = 8;
  localparam int ST_LVL_LSB   = 12;

  // ===========================================================
  // widths and reset values
  localparam int         PRI_W       = 3;
  localparam logic       GATE_EN_RST = 1'b0;
  localparam logic       AUTO_RST    = 1'b0;
  localparam logic [2:0] PRI_RST     = 3'h0;
  localparam logic [1:0] MODE0_LOW   = 2'h0;

  // ===========================================================
  // timing, in states, and derived cycle counts
  localparam int         MASK_DELAY_STATES = 2;
  localparam int         BLOCK_STATES      = 3;
  localparam int         CYC_PER_STATE     = 1;
  localparam int         MASK_DELAY_CYC    = MASK_DELAY_STATES * CYC_PER_STATE;
  localparam logic [1:0] BLOCK_CYC = 2'(BLOCK_STATES * CYC_PER_STATE);

endpackage

/* File: tb/cpu_dma_priority_gate_tb.sv */
// Purpose: self-checking bench for the cpu/dma priority gate
// Assumes: one wait state on the register bus
// Notes:   random levels from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module cpu_dma_priority_gate_tb;
  import prio_gate_pkg::*;
  // ===========================================================
  // signals
  logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, irq_req;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable, irq_accept_id;
  logic        ccr_mask_bit, int_ctrl_mode2, ctrl_insn_done, insn_end;
  logic        block_move_byte, block_move_word, string_block_transfer;
  logic        transfer_cycle_end, nmi_req, irq_accept, irq_accept_nmi;
  logic        save_pc_at_insn, slow;
  logic [2:0]  interrupt_mask_level, lvl, m;
  logic [3:0]  src_req, dma_access_done, dma_act_req, cpu_src_req;
  logic [3:0]  src_clear, exp_clr, en_m, own_m;
  logic [2:0]  pri [4];
  int          error_cnt, total_checks, i, c;
  integer      seed;
  cpu_dma_priority_gate #(.NCH(4), .NIRQ(8)) dut (
    .clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ccr_mask_bit,
    .interrupt_mask_level, .int_ctrl_mode2, .ctrl_insn_done, .insn_end,
    .block_move_byte, .block_move_word, .string_block_transfer,
    .transfer_cycle_end, .nmi_req, .irq_req, .irq_accept, .irq_accept_nmi,
    .irq_accept_id, .save_pc_at_insn, .src_req, .dma_access_done,
    .dma_act_req, .cpu_src_req, .src_clear);
  dma_chan_model #(.NCH(4)) dma (.clk_sys, .nrst, .act(dma_act_req),
    .slow, .done(dma_access_done));
  // ===========================================================
  // helpers
  task automatic check(input logic [31:0] seen, exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    // look at waitrequest once it has settled, before the edge it qualifies
    for (n = 0; n < 20; n++) begin
      #1;
      if (avs_waitrequest === 1'b0)
        break;
      @(posedge clk_sys);
    end
    if (n == 20) begin
      error_cnt++;
      tally_and_finish();
    end
    // the edge with waitrequest low: write lands, read data stands
    @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wch(input int k);
    bus(1'b1, CH_BASE_OFS + CH_STRIDE * 8'(k),
        {27'h0, en_m[k], own_m[k], pri[k]});
  endtask
  function automatic logic [3:0] exp_held(input logic [2:0] l);
    logic [3:0] h;
    for (int k = 0; k < 4; k++)
      h[k] = l > pri[k];
    return h;
  endfunction
  // event pulse; accept is looked at in the cycle after the window
  task automatic ev(input logic [2:0] k, output logic [1:0] a);
    {ctrl_insn_done, transfer_cycle_end, insn_end} <= k;
    @(posedge clk_sys);
    {ctrl_insn_done, transfer_cycle_end, insn_end} <= 3'h0;
    #1 a = {irq_accept_nmi & irq_accept, irq_accept};
    @(posedge clk_sys);
  endtask
  task automatic acc_case(input logic [8:0] r, input logic [2:0] k,
                          input logic [1:0] e, input logic [3:0] id);
    logic [1:0] a;
    if (r != 9'h0) begin
      {nmi_req, irq_req} <= r;
      @(posedge clk_sys);
      {nmi_req, irq_req} <= 9'h0;
    end
    ev(k, a);
    check(a, e, "accept");
    if (e == 2'b01)
      check(irq_accept_id, id, "accept id");
  endtask
  // ===========================================================
  // clock, clear scoreboard, sequence
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (nrst === 1'b1)
      check(src_clear, exp_clr, "src clear");
    exp_clr <= dma_access_done & en_m & own_m;
  end
  initial begin
    seed = 32'h5588;
    {nrst, avs_read, avs_write, ccr_mask_bit, int_ctrl_mode2, slow} = '0;
    {ctrl_insn_done, insn_end, block_move_byte, block_move_word} = '0;
    {string_block_transfer, transfer_cycle_end, nmi_req} = '0;
    {avs_address, irq_req, avs_writedata, interrupt_mask_level} = '0;
    {src_req, exp_clr, avs_byteenable, en_m, own_m} = 20'h00f75;
    {error_cnt, total_checks} = '0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, PRIO_CTRL_OFS, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    bus(1'b0, 8'hfc, 32'h0);
    check(rd, 32'h0, "unmapped");
    $display("end reset test");
    src_req <= 4'hf;
    bus(1'b1, PRIO_CTRL_OFS, 32'h07);
    for (c = 0; c < 4; c++) begin
      pri[c] = 3'h0;
      wch(c);
    end
    check(dma_act_req, en_m, "ungated");
    check(cpu_src_req, 4'ha, "cpu route");
    // first two rounds hit the equal and one-above boundary
    for (i = 0; i < 8; i++) begin
      lvl = (i == 0) ? 3'h5 : (i == 1) ? 3'h6 : 3'($random(seed));
      for (c = 0; c < 4; c++) begin
        pri[c] = (i < 2) ? 3'h5 : 3'($random(seed));
        wch(c);
      end
      src_req <= 4'($random(seed));
      slow <= i[0];
      bus(1'b1, PRIO_CTRL_OFS, {24'h0, 8'h80 | 8'(lvl)});
      check(dma_act_req, src_req & en_m & ~exp_held(lvl), "gate");
      bus(1'b0, STATUS_OFS, 32'h0);
      check(rd[3:0], exp_held(lvl), "held");
      check(rd[14:12], lvl, "manual lvl");
    end
    $display("end gate test");
    int_ctrl_mode2 <= 1'b1;
    m = 3'($random(seed));
    interrupt_mask_level <= m;
    bus(1'b1, PRIO_CTRL_OFS, 32'h40);
    bus(1'b1, PRIO_CTRL_OFS, {29'h8, ~m});
    bus(1'b0, STATUS_OFS, 32'h0);
    check(rd[14:12], m, "mode2 lvl");
    int_ctrl_mode2 <= 1'b0;
    for (i = 0; i < 2; i++) begin
      ccr_mask_bit <= !i[0];
      repeat (3) @(posedge clk_sys);
      bus(1'b0, STATUS_OFS, 32'h0);
      check(rd[14:12], i ? 3'h0 : 3'h4, "mode0 lvl");
    end
    $display("end auto test");
    acc_case(9'h004, 3'b001, 2'b01, 4'h2);
    acc_case(9'h022, 3'b001, 2'b01, 4'h5);
    acc_case(9'h180, 3'b001, 2'b11, 4'h0);
    acc_case(9'h000, 3'b001, 2'b01, 4'h7);
    acc_case(9'h008, 3'b101, 2'b00, 4'h0);
    acc_case(9'h000, 3'b001, 2'b00, 4'h0);
    acc_case(9'h000, 3'b001, 2'b01, 4'h3);
    fork
      bus(1'b1, PRIO_CTRL_OFS, 32'h0);
      acc_case(9'h001, 3'b001, 2'b00, 4'h0);
    join
    acc_case(9'h000, 3'b001, 2'b01, 4'h0);
    block_move_byte <= 1'b1;
    acc_case(9'h010, 3'b011, 2'b00, 4'h0);
    block_move_byte <= 1'b0;
    acc_case(9'h000, 3'b001, 2'b01, 4'h4);
    for (i = 0; i < 2; i++) begin
      {string_block_transfer, block_move_word} <= i ? 2'b10 : 2'b01;
      acc_case(9'h002, 3'b010, 2'b01, 4'h1);
      check(save_pc_at_insn, i[0], "saved pc");
    end
    {string_block_transfer, block_move_word} <= 2'b00;
    $display("end accept test");
    tally_and_finish();
  end
endmodule
bind cpu_dma_priority_gate prio_gate_asserts #(.NCH(NCH), .NIRQ(NIRQ)) chk (
  .clk_sys, .nrst, .avs_write, .ctrl_insn_done, .insn_end,
  .transfer_cycle_end, .block_move_byte, .string_block_transfer, .nmi_req,
  .irq_accept, .irq_accept_nmi, .save_pc_at_insn, .src_req,
  .dma_access_done, .dma_act_req, .cpu_src_req, .src_clear);

/* File: tb/dma_chan_model.sv */
// Purpose: four channel dma controller answering activations
// Assumes: one access per activation, lowest channel first
// Notes:   slow adds idle cycles between accesses
`timescale 1ns/1ps
module dma_chan_model #(
  parameter int NCH = 4
) (
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  // gate side
  input  wire logic [NCH-1:0] act,
  input  wire logic           slow,
  output logic      [NCH-1:0] done
);
  logic [2:0] cnt_q;
  always @(posedge clk_sys) begin
    done <= '0;
    if (!nrst)
      cnt_q <= 3'h0;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
    else if (|act) begin
      // access only while the gate lets the request through
      done  <= act & ~(act - 1'b1);
      cnt_q <= slow ? 3'h5 : 3'h1;
    end
  end
endmodule

/* File: tb/prio_gate_asserts.sv */
// Purpose: port assertions for the priority gate
// Assumes: one clk_sys domain
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module prio_gate_asserts #(
  parameter int NCH  = 4,
  parameter int NIRQ = 8
) (
  // clock, reset, bus
  input wire logic           clk_sys,
  input wire logic           nrst,
  input wire logic           avs_write,
  // cpu events and acceptance
  input wire logic           ctrl_insn_done,
  input wire logic           insn_end,
  input wire logic           transfer_cycle_end,
  input wire logic           block_move_byte,
  input wire logic           string_block_transfer,
  input wire logic           nmi_req,
  input wire logic           irq_accept,
  input wire logic           irq_accept_nmi,
  input wire logic           save_pc_at_insn,
  // channels
  input wire logic [NCH-1:0] src_req,
  input wire logic [NCH-1:0] dma_access_done,
  input wire logic [NCH-1:0] dma_act_req,
  input wire logic [NCH-1:0] cpu_src_req,
  input wire logic [NCH-1:0] src_clear
);
  // ===========================================================
  // properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  chk_ctrl_block: assert property (
    ctrl_insn_done |=> !irq_accept [*4]) else $error("accept too soon");
  chk_write_block: assert property (
    irq_accept |-> !$past(avs_write)) else $error("accept in write");
  chk_window_only: assert property (
    irq_accept |-> $past(insn_end || transfer_cycle_end))
    else $error("accept off window");
  chk_byte_defer: assert property (
    irq_accept |-> !$past(block_move_byte)) else $error("byte move");
  chk_saved_pc: assert property (
    irq_accept |-> save_pc_at_insn == $past(string_block_transfer))
    else $error("saved pc kind");
  chk_nmi_first: assert property (
    irq_accept && $past(nmi_req) |-> irq_accept_nmi) else $error("nmi lost");
  chk_clear_cause: assert property (
    (src_clear & ~$past(dma_access_done)) == '0) else $error("stray clear");
  chk_act_source: assert property (
    (dma_act_req & ~src_req) == '0) else $error("act without source");
  chk_cpu_source: assert property (
    (cpu_src_req & ~src_req) == '0) else $error("cpu without source");
  cov_nmi: cover property (irq_accept && irq_accept_nmi);
  cov_string: cover property (irq_accept && save_pc_at_insn);
  cov_clear: cover property (|src_clear);
endmodule
